// ### design/store_unit_consts.vh
// Behaviour
// - decode byte/half/word/double stores from op3
// - alternate stores decoded, privileged in user mode
// - word full, half low 16, byte low 8
// - integer pair: even at ea, odd ea+4
// - odd rd on integer double: bad opcode
// - ea is src1+src2 or src1+signed_imm_field
// - alternate uses insn space id; i=1 traps
// - normal stores pick user/system space by supervisor
// - each store atomic, pair held locked
// - integer misalignment traps by access size
// - decode float single/state/queue/double; queue privileged
// - float pair: even at ea, odd ea+4
// - odd rd float double: float fault, bad reg
// - queue store writes front doubleword entry
// - no queue: float fault, type 4
// - empty queue: float fault, queue order
// - state store waits for busy float operates
// - state store may clear trap type after
// - float misalignment: word or doubleword
// - float store disabled or absent: float off
// - second word fault may leave first written
`ifndef STORE_UNIT_CONSTS_VH
`define STORE_UNIT_CONSTS_VH

// ==========================================
// instruction fields
`define OP_HI          31
`define OP_LO          30
`define RD_HI          29
`define RD_LO          25
`define OP3_HI         24
`define OP3_LO         19
`define SRC1_HI        18
`define SRC1_LO        14
`define IMM_BIT        13
`define SPACE_HI       12
`define SPACE_LO       5
`define SRC2_HI        4
`define SRC2_LO        0
`define IMM13_HI       12
`define OP_MEMORY      2'h3

// ==========================================
// op3 encodings
`define OP3_BYTE       6'h05
`define OP3_HALF       6'h06
`define OP3_WORD       6'h04
`define OP3_DOUBLE     6'h07
`define OP3_BYTE_ALT   6'h15
`define OP3_HALF_ALT   6'h16
`define OP3_WORD_ALT   6'h14
`define OP3_DOUBLE_ALT 6'h17
`define OP3_FSINGLE    6'h24
`define OP3_FSTATE     6'h25
`define OP3_FQUEUE     6'h26
`define OP3_FDOUBLE    6'h27

// ==========================================
// trap codes on trap_code
`define TRAP_NONE      4'h0
`define TRAP_PRIV      4'h1
`define TRAP_BAD_OP    4'h2
`define TRAP_MISALIGN  4'h3
`define TRAP_FLOAT_OFF 4'h4
`define TRAP_FLOAT     4'h5
`define TRAP_ACCESS    4'h6

// float trap type values
`define FTT_NONE       3'h0
`define FTT_QUEUE_ORD  3'h4
`define FTT_BAD_REG    3'h6

// address spaces for normal stores
`define SPACE_USER     8'h0a
`define SPACE_SYSTEM   8'h0b

// byte enables, big-endian lanes
`define BE_NONE        4'h0
`define BE_WORD        4'hf
`define BE_HALF_HI     4'hc
`define BE_HALF_LO     4'h3
`define BE_BYTE0       4'h8

// second word offset
`define PAIR_STEP      32'h0000_0004

`endif

// ### design/store_ea_gen.v
`timescale 1ns/10ps
`include "store_unit_consts.vh"

module store_ea_gen (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  input  wire        ce,
  // operands
  input  wire        load,
  input  wire [31:0] src1_val,
  input  wire [31:0] src2_val,
  input  wire        imm_flag,
  input  wire [12:0] imm13,
  // result
  output reg  [31:0] ea_r
);

  // sign-extended immediate
  wire [31:0] imm_ext = {{19{imm13[`IMM13_HI]}}, imm13};
  // second operand select
  wire [31:0] operand = imm_flag ? imm_ext : src2_val;

  // ==========================================
  // registered sum, ready one cycle after load
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ea_r <= 32'h0000_0000;
    end else if (ce && load) begin
      ea_r <= src1_val + operand;
    end
  end

endmodule

// ### design/store_instruction_unit.v
`timescale 1ns/10ps
`include "store_unit_consts.vh"

module store_instruction_unit #(
  parameter FQ_PRESENT  = 1'b1,  // deferred queue built in
  parameter FPU_PRESENT = 1'b1,  // float unit built in
  parameter CLEAR_FTT   = 1'b1   // clear trap type after state store
) (
  // clock, enable, reset
  input  wire        clk,
  input  wire        ce,
  input  wire        resetn,
  // instruction issue
  input  wire        insn_valid,
  input  wire [31:0] insn,
  input  wire [31:0] src1_val,
  input  wire [31:0] src2_val,
  // store data sources
  input  wire [31:0] int_even_val,
  input  wire [31:0] int_odd_val,
  input  wire [31:0] fp_even_val,
  input  wire [31:0] fp_odd_val,
  input  wire [31:0] fsr_val,
  input  wire [31:0] fq_front_hi,
  input  wire [31:0] fq_front_lo,
  // processor state
  input  wire        supervisor,
  input  wire        fp_enable_flag,
  input  wire        fq_nonempty,
  input  wire        fp_operate_insn_busy,
  // memory write port
  input  wire        mem_ack,
  input  wire        mem_err,
  output reg         mem_req_r,
  output reg  [31:0] mem_addr_r,
  output reg  [31:0] mem_data_r,
  output reg  [3:0]  mem_be_r,
  output reg  [7:0]  mem_space_r,
  output reg         mem_lock_r,
  // status
  output reg         insn_ready_r,
  output reg         done_r,
  output reg         trap_valid_r,
  output reg  [3:0]  trap_code_r,
  output reg  [2:0]  ftt_r,
  output reg         ftt_clear_r
);

  // ==========================================
  // states
  localparam S_IDLE  = 3'h0;
  localparam S_CHECK = 3'h1;
  localparam S_FWAIT = 3'h2;
  localparam S_WR1   = 3'h3;
  localparam S_WR2   = 3'h4;

  // ==========================================
  // decode helpers
  // integer store class, alternate or not
  function is_int;
    input [5:0] o;
    begin
      is_int = (o == `OP3_BYTE) || (o == `OP3_HALF) || (o == `OP3_WORD) ||
               (o == `OP3_DOUBLE) || is_alt(o);
    end
  endfunction

  // alternate space store
  function is_alt;
    input [5:0] o;
    begin
      is_alt = (o == `OP3_BYTE_ALT) || (o == `OP3_HALF_ALT) ||
               (o == `OP3_WORD_ALT) || (o == `OP3_DOUBLE_ALT);
    end
  endfunction

  // float store class
  function is_fp;
    input [5:0] o;
    begin
      is_fp = (o == `OP3_FSINGLE) || (o == `OP3_FSTATE) ||
              (o == `OP3_FQUEUE) || (o == `OP3_FDOUBLE);
    end
  endfunction

  // two-word stores
  function is_pair;
    input [5:0] o;
    begin
      is_pair = (o == `OP3_DOUBLE) || (o == `OP3_DOUBLE_ALT) ||
                (o == `OP3_FDOUBLE) || (o == `OP3_FQUEUE);
    end
  endfunction

  // ==========================================
  // reset release through two flops
  reg rst_meta_r;
  reg rst_n_r;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // ==========================================
  // latched instruction and operands
  reg  [2:0]  state_r;
  reg  [4:0]  rd_r;        // destination field
  reg  [5:0]  op3_r;       // operation field
  reg         opok_r;      // op field was memory class
  reg         imm_r;       // immediate flag
  reg  [7:0]  space_r;     // space id from insn
  reg         super_r;     // supervisor at issue
  reg  [31:0] word2_r;     // second word data held for atomic pair
  wire [31:0] ea;

  // field extraction at issue
  wire [1:0]  f_op    = insn[`OP_HI:`OP_LO];
  wire [4:0]  f_rd    = insn[`RD_HI:`RD_LO];
  wire [5:0]  f_op3   = insn[`OP3_HI:`OP3_LO];
  wire [4:0]  f_src1  = insn[`SRC1_HI:`SRC1_LO];
  wire        f_imm   = insn[`IMM_BIT];
  wire [7:0]  f_space = insn[`SPACE_HI:`SPACE_LO];
  wire [4:0]  f_src2  = insn[`SRC2_HI:`SRC2_LO];
  // ready must be up too: the first idle cycle after a trap or done is not yet open
  wire        take    = insn_valid && (state_r == S_IDLE) && insn_ready_r;

  // register numbers are resolved outside; kept for clarity only
  wire        unused_fields = |{f_src1, f_src2};

  // address generator, result ready in S_CHECK
  store_ea_gen u_ea (
    .clk      (clk),
    .rst_n    (rst_n_r),
    .ce       (ce),
    .load     (take),
    .src1_val (src1_val),
    .src2_val (src2_val),
    .imm_flag (f_imm),
    .imm13    (insn[`IMM13_HI:0]),
    .ea_r     (ea)
  );

  // ==========================================
  // trap evaluation on the latched instruction
  reg [3:0] chk_code;
  reg [2:0] chk_ftt;
  reg       chk_mis;
  always @* begin
    chk_code = `TRAP_NONE;
    chk_ftt  = `FTT_NONE;
    // alignment by access size
    case (op3_r)
      `OP3_HALF, `OP3_HALF_ALT:                     chk_mis = ea[0];
      `OP3_WORD, `OP3_WORD_ALT:                     chk_mis = |ea[1:0];
      `OP3_FSINGLE, `OP3_FSTATE:                    chk_mis = |ea[1:0];
      `OP3_DOUBLE, `OP3_DOUBLE_ALT:                 chk_mis = |ea[2:0];
      `OP3_FDOUBLE, `OP3_FQUEUE:                    chk_mis = |ea[2:0];
      default:                                      chk_mis = 1'b0;
    endcase
    // priority: decode, privilege, odd rd on integer double, disable, float faults, alignment
    if (!opok_r || !(is_int(op3_r) || is_fp(op3_r))) begin
      chk_code = `TRAP_BAD_OP;
    end else if (is_alt(op3_r) && imm_r) begin
      chk_code = `TRAP_BAD_OP;
    end else if ((is_alt(op3_r) || op3_r == `OP3_FQUEUE) && !super_r) begin
      chk_code = `TRAP_PRIV;
    end else if ((op3_r == `OP3_DOUBLE || op3_r == `OP3_DOUBLE_ALT) && rd_r[0]) begin
      chk_code = `TRAP_BAD_OP;
    end else if (is_fp(op3_r) && (!fp_enable_flag || !FPU_PRESENT)) begin
      chk_code = `TRAP_FLOAT_OFF;
    end else if (op3_r == `OP3_FDOUBLE && rd_r[0]) begin
      chk_code = `TRAP_FLOAT;
      chk_ftt  = `FTT_BAD_REG;
    end else if (op3_r == `OP3_FQUEUE && !FQ_PRESENT) begin
      chk_code = `TRAP_FLOAT;
      chk_ftt  = `FTT_QUEUE_ORD;
    end else if (op3_r == `OP3_FQUEUE && !fq_nonempty) begin
      chk_code = `TRAP_FLOAT;
      chk_ftt  = `FTT_QUEUE_ORD;
    end else if (chk_mis) begin
      chk_code = `TRAP_MISALIGN;
    end
  end

  // ==========================================
  // first word data and lanes
  reg [31:0] w1_data;
  reg [31:0] w2_data;
  reg [3:0]  w1_be;
  always @* begin
    w1_be   = `BE_WORD;
    w2_data = int_odd_val;
    case (op3_r)
      // byte: low 8 bits on every lane, one lane enabled
      `OP3_BYTE, `OP3_BYTE_ALT: begin
        w1_data = {4{int_even_val[7:0]}};
        w1_be   = `BE_BYTE0 >> ea[1:0];
      end
      // halfword: low 16 bits, upper or lower half
      `OP3_HALF, `OP3_HALF_ALT: begin
        w1_data = {2{int_even_val[15:0]}};
        w1_be   = ea[1] ? `BE_HALF_LO : `BE_HALF_HI;
      end
      `OP3_FSINGLE: begin
        w1_data = fp_even_val;
      end
      `OP3_FDOUBLE: begin
        w1_data = fp_even_val;
        w2_data = fp_odd_val;
      end
      `OP3_FSTATE: begin
        w1_data = fsr_val;
      end
      `OP3_FQUEUE: begin
        w1_data = fq_front_hi;
        w2_data = fq_front_lo;
      end
      default: begin
        w1_data = int_even_val;
      end
    endcase
  end

  // space: insn field for alternate, else by supervisor flag
  wire [7:0] space_sel = is_alt(op3_r) ? space_r :
                         (super_r ? `SPACE_SYSTEM : `SPACE_USER);

  // ==========================================
  // main sequencer
  always @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r      <= S_IDLE;
      rd_r         <= 5'h00;
      op3_r        <= 6'h00;
      opok_r       <= 1'b0;
      imm_r        <= 1'b0;
      space_r      <= 8'h00;
      super_r      <= 1'b0;
      word2_r      <= 32'h0000_0000;
      mem_req_r    <= 1'b0;
      mem_addr_r   <= 32'h0000_0000;
      mem_data_r   <= 32'h0000_0000;
      mem_be_r     <= `BE_NONE;
      mem_space_r  <= 8'h00;
      mem_lock_r   <= 1'b0;
      insn_ready_r <= 1'b0;
      done_r       <= 1'b0;
      trap_valid_r <= 1'b0;
      trap_code_r  <= `TRAP_NONE;
      ftt_r        <= `FTT_NONE;
      ftt_clear_r  <= 1'b0;
    end else if (ce) begin
      // pulses default low
      done_r       <= 1'b0;
      trap_valid_r <= 1'b0;
      ftt_clear_r  <= 1'b0;
      case (state_r)
        // wait for an instruction
        S_IDLE: begin
          insn_ready_r <= 1'b1;
          if (take) begin
            insn_ready_r <= 1'b0;
            rd_r         <= f_rd;
            op3_r        <= f_op3;
            opok_r       <= (f_op == `OP_MEMORY) | (unused_fields & 1'b0);
            imm_r        <= f_imm;
            space_r      <= f_space;
            super_r      <= supervisor;
            state_r      <= S_CHECK;
          end
        end
        // address known: trap or start the write
        S_CHECK: begin
          if (chk_code != `TRAP_NONE) begin
            trap_valid_r <= 1'b1;
            trap_code_r  <= chk_code;
            ftt_r        <= chk_ftt;
            state_r      <= S_IDLE;
          end else begin
            // capture data now so the pair goes out unbroken
            mem_addr_r  <= ea;
            mem_data_r  <= w1_data;
            mem_be_r    <= w1_be;
            mem_space_r <= space_sel;
            word2_r     <= w2_data;
            trap_code_r <= `TRAP_NONE;
            if (op3_r == `OP3_FSTATE && fp_operate_insn_busy) begin
              state_r <= S_FWAIT;
            end else begin
              mem_req_r  <= 1'b1;
              mem_lock_r <= is_pair(op3_r);
              state_r    <= S_WR1;
            end
          end
        end
        // state register only leaves once operates drain
        S_FWAIT: begin
          if (!fp_operate_insn_busy) begin
            mem_data_r <= fsr_val;
            mem_req_r  <= 1'b1;
            state_r    <= S_WR1;
          end
        end
        // first word
        S_WR1: begin
          if (mem_ack) begin
            if (mem_err) begin
              mem_req_r    <= 1'b0;
              mem_lock_r   <= 1'b0;
              trap_valid_r <= 1'b1;
              trap_code_r  <= `TRAP_ACCESS;
              state_r      <= S_IDLE;
            end else if (is_pair(op3_r)) begin
              // lock stays high between the two words
              mem_addr_r <= mem_addr_r + `PAIR_STEP;
              mem_data_r <= word2_r;
              mem_be_r   <= `BE_WORD;
              state_r    <= S_WR2;
            end else begin
              mem_req_r   <= 1'b0;
              mem_be_r    <= `BE_NONE;
              done_r      <= 1'b1;
              ftt_clear_r <= CLEAR_FTT && (op3_r == `OP3_FSTATE);
              state_r     <= S_IDLE;
            end
          end
        end
        // second word; a fault here leaves the first in memory
        S_WR2: begin
          if (mem_ack) begin
            mem_req_r  <= 1'b0;
            mem_lock_r <= 1'b0;
            mem_be_r   <= `BE_NONE;
            state_r    <= S_IDLE;
            if (mem_err) begin
              trap_valid_r <= 1'b1;
              trap_code_r  <= `TRAP_ACCESS;
            end else begin
              done_r <= 1'b1;
            end
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// ### verification/store_unit_asserts.sv
`timescale 1ns/10ps
`include "store_unit_consts.vh"

// ==========================================
// port checker for the store unit
module store_unit_asserts (
  // clock and reset
  input wire        clk,
  input wire        ce,
  input wire        resetn,
  // issue side
  input wire        insn_valid,
  input wire [31:0] insn,
  input wire        supervisor,
  input wire        fp_enable_flag,
  input wire        fp_operate_insn_busy,
  // memory side
  input wire        mem_ack,
  input wire        mem_err,
  input wire        mem_req_r,
  input wire [31:0] mem_addr_r,
  input wire [31:0] mem_data_r,
  input wire        mem_lock_r,
  // status
  input wire        insn_ready_r,
  input wire        trap_valid_r,
  input wire [3:0]  trap_code_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  wire       take = ce && insn_valid && insn_ready_r;            // accepted request
  wire [5:0] op3  = insn[`OP3_HI:`OP3_LO];                       // opcode field
  wire       mop  = insn[`OP_HI:`OP_LO] == `OP_MEMORY;           // memory format
  wire       alt  = mop && (op3[5:2] == 4'h5);                   // alternate group
  wire       flt  = mop && (op3[5:2] == 4'h9);                   // float group

  // ==========================================
  // sequences
  sequence s_fsr_busy;
    take && flt && (op3 == `OP3_FSTATE) ##1 fp_operate_insn_busy;
  endsequence
  sequence s_foff;
    take && flt && (op3 != `OP3_FQUEUE) ##1 !fp_enable_flag;
  endsequence

  // ==========================================
  // properties
  property p_ready_drop;
    take |=> !insn_ready_r;
  endproperty
  property p_alt_user;
    take && alt && !insn[`IMM_BIT] && !supervisor |-> ##2 trap_valid_r && trap_code_r == `TRAP_PRIV;
  endproperty
  property p_alt_imm;
    take && alt && insn[`IMM_BIT] |-> ##2 trap_valid_r && trap_code_r == `TRAP_BAD_OP;
  endproperty
  property p_byte;
    take && mop && op3 == `OP3_BYTE |-> ##2 !(trap_valid_r && trap_code_r == `TRAP_MISALIGN);
  endproperty
  property p_pair_step;
    mem_req_r && mem_lock_r && mem_ack && !mem_err && !mem_addr_r[2]
      |=> mem_req_r && mem_lock_r && mem_addr_r == $past(mem_addr_r) + `PAIR_STEP;
  endproperty
  property p_hold;
    mem_req_r && !mem_ack |=> mem_req_r && $stable(mem_addr_r) && $stable(mem_data_r)
      && $stable(mem_lock_r);
  endproperty
  property p_fault;
    mem_req_r && mem_ack && mem_err |=> trap_valid_r && trap_code_r == `TRAP_ACCESS && !mem_req_r;
  endproperty
  property p_fwait;
    s_fsr_busy |=> !mem_req_r;
  endproperty
  property p_foff;
    s_foff |=> trap_valid_r && trap_code_r == `TRAP_FLOAT_OFF;
  endproperty

  a_ready_drop: assert property (p_ready_drop) else $error("unit took a second request");
  a_alt_user: assert property (p_alt_user) else $error("user alternate store not refused");
  a_alt_imm: assert property (p_alt_imm) else $error("alternate store with imm not refused");
  a_byte: assert property (p_byte) else $error("byte store took misalign trap");
  a_pair_step: assert property (p_pair_step) else $error("pair second word not at ea+4");
  a_hold: assert property (p_hold) else $error("write changed before ack");
  a_fault: assert property (p_fault) else $error("second word fault not reported");
  a_fwait: assert property (p_fwait) else $error("state store did not wait");
  a_foff: assert property (p_foff) else $error("disabled float store not refused");
endmodule

bind store_instruction_unit store_unit_asserts i_store_unit_asserts (.clk, .ce, .resetn,
  .insn_valid, .insn, .supervisor, .fp_enable_flag, .fp_operate_insn_busy, .mem_ack, .mem_err,
  .mem_req_r, .mem_addr_r, .mem_data_r, .mem_lock_r, .insn_ready_r, .trap_valid_r,
  .trap_code_r);

// ### verification/mem_model.sv
`timescale 1ns/10ps

// ==========================================
// memory taking write words, records them
module mem_model (
  // clock
  input  wire        clk,
  // write port
  input  wire        req,
  input  wire [31:0] addr,
  input  wire [31:0] data,
  input  wire [3:0]  be,
  input  wire [7:0]  space,
  // knobs
  input  wire [1:0]  dly,
  input  wire        err2,
  // completion
  output reg         ack,
  output reg         err
);
  reg [1:0]  cnt = 2'h0;  // wait cycles spent
  integer    nw  = 0;     // words taken, cleared by bench
  reg [31:0] wa [0:1];    // word addresses
  reg [31:0] wd [0:1];    // word data
  reg [3:0]  wbe;         // first word lanes
  reg [7:0]  wsp;         // first word space
  time       wt;          // first word time

  initial begin
    ack = 1'b0;
    err = 1'b0;
  end

  // ack is a one-cycle pulse, so each word is seen once
  always @(posedge clk) begin
    ack <= 1'b0;
    err <= 1'b0;
    if (req && ack) begin
      if (nw < 2) begin
        wa[nw] <= addr;
        wd[nw] <= data;
      end
      if (nw == 0) begin
        wbe <= be;
        wsp <= space;
        wt  <= $time;
      end
      nw  <= nw + 1;
      cnt <= 2'h0;
    end else if (req) begin
      if (cnt == dly) begin
        ack <= 1'b1;
        err <= err2 && (nw == 1);  // fault only second word
      end else begin
        cnt <= cnt + 2'h1;
      end
    end
  end
endmodule

// ### verification/tb.sv
`timescale 1ns/10ps
`include "store_unit_consts.vh"

// ==========================================
// bench for the store unit
module tb;
  reg         clk = 1'b0;
  reg         resetn = 1'b0;
  reg         insn_valid = 1'b0;
  reg  [31:0] insn = 32'h0, src1_val = 32'h0, src2_val = 32'h0;
  reg  [31:0] iev = 32'h0, iod = 32'h0, fev = 32'h0, fod = 32'h0;
  reg  [31:0] fsr = 32'h0, fqh = 32'h0, fql = 32'h0;
  reg         sup = 1'b1, fpe = 1'b1, fqne = 1'b1, busy = 1'b0;
  reg  [1:0]  dly = 2'h0;     // memory wait cycles
  reg         e2 = 1'b0;      // fault on second word
  wire        mem_ack, mem_err, mem_req_r, mem_lock_r, insn_ready_r;
  wire        done_r, trap_valid_r, ftt_clear_r;
  wire [31:0] mem_addr_r, mem_data_r;
  wire [3:0]  mem_be_r, trap_code_r;
  wire [7:0]  mem_space_r;
  wire [2:0]  ftt_r;
  integer     num_errors = 0, n_compared = 0, cyc = 0, k;
  reg  [3:0]  res;            // 0 done, else trap code
  reg         clr;            // trap type clear seen
  reg  [5:0]  o;
  reg  [4:0]  rd;
  reg  [31:0] a;
  reg  [3:0]  e;
  time        trel;

  always #5 clk = ~clk;

  store_instruction_unit i_store_instruction_unit (.clk(clk), .ce(1'b1), .resetn(resetn),
    .insn_valid(insn_valid), .insn(insn), .src1_val(src1_val), .src2_val(src2_val),
    .int_even_val(iev), .int_odd_val(iod), .fp_even_val(fev), .fp_odd_val(fod),
    .fsr_val(fsr), .fq_front_hi(fqh), .fq_front_lo(fql), .supervisor(sup),
    .fp_enable_flag(fpe), .fq_nonempty(fqne), .fp_operate_insn_busy(busy), .mem_ack(mem_ack),
    .mem_err(mem_err), .mem_req_r(mem_req_r), .mem_addr_r(mem_addr_r),
    .mem_data_r(mem_data_r), .mem_be_r(mem_be_r), .mem_space_r(mem_space_r),
    .mem_lock_r(mem_lock_r), .insn_ready_r(insn_ready_r), .done_r(done_r),
    .trap_valid_r(trap_valid_r), .trap_code_r(trap_code_r), .ftt_r(ftt_r),
    .ftt_clear_r(ftt_clear_r));

  mem_model i_mem_model (.clk(clk), .req(mem_req_r), .addr(mem_addr_r), .data(mem_data_r),
    .be(mem_be_r), .space(mem_space_r), .dly(dly), .err2(e2), .ack(mem_ack), .err(mem_err));

  // ==========================================
  // helpers
  function [31:0] mk(input [4:0] d, input [5:0] c, input i, input [12:0] lo);
    mk = {`OP_MEMORY, d, c, 5'h01, i, lo};  // src1 field fixed
  endfunction

  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask

  // offer one store, wait for done or trap under a bound
  task go(input [31:0] w, input [31:0] s1, input [31:0] s2);
    integer n;
    begin
      i_mem_model.nw = 0;
      clr = 1'b0;
      res = 4'hf;
      insn <= w;
      src1_val <= s1;
      src2_val <= s2;
      insn_valid <= 1'b1;
      do @(negedge clk); while (insn_ready_r !== 1'b1);
      @(posedge clk);
      insn_valid <= 1'b0;
      for (n = 0; n < 100 && res === 4'hf; n = n + 1) begin
        @(negedge clk);
        if (ftt_clear_r === 1'b1) clr = 1'b1;
        if (done_r === 1'b1) res = `TRAP_NONE;
        else if (trap_valid_r === 1'b1) res = trap_code_r;
      end
      @(negedge clk);
      if (ftt_clear_r === 1'b1) clr = 1'b1;
      @(posedge clk);
    end
  endtask

  // ==========================================
  // scenarios
  task t_word;
    begin
      sup <= 1'b1;
      iev <= 32'h1234_5678;
      go(mk(5'h02, `OP3_WORD, 1'b1, 13'h1ffc), 32'h0000_0108, 32'h0);
      chk(res, `TRAP_NONE);
      chk(i_mem_model.wa[0], 32'h0000_0104);
      chk(i_mem_model.wd[0], 32'h1234_5678);
      chk(i_mem_model.wbe, `BE_WORD);
      chk(i_mem_model.wsp, `SPACE_SYSTEM);
    end
  endtask

  task t_small;
    begin
      sup <= 1'b0;
      iev <= 32'haabb_ccdd;
      go(mk(5'h02, `OP3_BYTE, 1'b0, 13'h0002), 32'h0000_0201, 32'h2);
      chk(res, `TRAP_NONE);
      chk(i_mem_model.wbe, 4'h1);
      chk(i_mem_model.wd[0][7:0], 8'hdd);
      chk(i_mem_model.wsp, `SPACE_USER);
      go(mk(5'h02, `OP3_HALF, 1'b0, 13'h0002), 32'h0000_0200, 32'h2);
      chk(i_mem_model.wbe, 4'h3);
      chk(i_mem_model.wd[0][15:0], 16'hccdd);
    end
  endtask

  task t_pair;
    begin
      dly <= 2'h2;
      sup <= 1'b1;
      iev <= 32'h1111_0000;
      iod <= 32'h2222_0000;
      go(mk(5'h04, `OP3_DOUBLE, 1'b0, 13'h0002), 32'h0000_0400, 32'h8);
      chk(i_mem_model.nw, 2);
      chk(i_mem_model.wa[1], 32'h0000_040c);
      chk({i_mem_model.wd[0], i_mem_model.wd[1]}, {iev, iod});
      dly <= 2'h0;
    end
  endtask

  task t_alt;
    begin
      sup <= 1'b1;
      go(mk(5'h02, `OP3_WORD_ALT, 1'b0, {8'h5a, 5'h03}), 32'h0000_0300, 32'h0);
      chk(i_mem_model.wsp, 8'h5a);
      go(mk(5'h02, `OP3_BYTE_ALT, 1'b1, 13'h0004), 32'h0000_0300, 32'h0);
      chk(res, `TRAP_BAD_OP);
      sup <= 1'b0;
      for (k = 0; k < 4; k = k + 1) begin
        go(mk(5'h02, `OP3_WORD_ALT + k[5:0], 1'b0, 13'h0003), 32'h0000_0300, 32'h0);
        chk(res, `TRAP_PRIV);
      end
    end
  endtask

  task t_traps;
    begin
      for (k = 0; k < 12; k = k + 1) begin
        rd = 5'h02;
        a = 32'h0;
        // one assignment per flag per step: k alone picks the flag to drop; the case picks opcode, offset and expected trap
        sup <= (k != 11);
        fpe <= (k != 10);
        fqne <= (k != 9);
        e = `TRAP_MISALIGN;
        case (k)
          0: begin o = `OP3_WORD; a = 32'h2; end
          1: begin o = `OP3_HALF; a = 32'h1; end
          2: begin o = `OP3_DOUBLE; a = 32'h4; end
          3: begin o = `OP3_FSINGLE; a = 32'h2; end
          4: begin o = `OP3_FSTATE; a = 32'h2; end
          5: begin o = `OP3_FDOUBLE; a = 32'h4; end
          6: begin o = `OP3_FQUEUE; a = 32'h4; end
          7: begin o = `OP3_DOUBLE; rd = 5'h03; e = `TRAP_BAD_OP; end
          8: begin o = `OP3_FDOUBLE; rd = 5'h03; e = `TRAP_FLOAT; end
          9: begin o = `OP3_FQUEUE; e = `TRAP_FLOAT; end
          10: begin o = `OP3_FSINGLE; e = `TRAP_FLOAT_OFF; end
          default: begin o = `OP3_FQUEUE; e = `TRAP_PRIV; end
        endcase
        go(mk(rd, o, 1'b0, 13'h0002), 32'h0000_0700, a);
        chk(res, e);
        if (k == 8) chk(ftt_r, `FTT_BAD_REG);
        if (k == 9) chk(ftt_r, `FTT_QUEUE_ORD);
      end
    end
  endtask

  task t_float;
    begin
      sup <= 1'b1;
      fpe <= 1'b1;
      fqne <= 1'b1;
      fev <= 32'h3f80_0000;
      fod <= 32'h4000_0000;
      fqh <= 32'h0000_0abc;
      fql <= 32'h8100_0000;
      fsr <= 32'h0001_c000;
      go(mk(5'h02, `OP3_FSINGLE, 1'b0, 13'h0002), 32'h0000_0500, 32'h0);
      chk(i_mem_model.wd[0], fev);
      go(mk(5'h02, `OP3_FDOUBLE, 1'b0, 13'h0002), 32'h0000_0508, 32'h0);
      chk({i_mem_model.wa[1], i_mem_model.wd[0], i_mem_model.wd[1]},
          {32'h0000_050c, fev, fod});
      go(mk(5'h00, `OP3_FQUEUE, 1'b0, 13'h0002), 32'h0000_0510, 32'h0);
      chk({i_mem_model.wd[0], i_mem_model.wd[1]}, {fqh, fql});
      busy <= 1'b1;
      fork
        go(mk(5'h00, `OP3_FSTATE, 1'b0, 13'h0002), 32'h0000_0520, 32'h0);
        begin
          repeat (8) @(posedge clk);
          busy <= 1'b0;
          trel = $time;
        end
      join
      chk(i_mem_model.wt > trel, 1);
      chk(i_mem_model.wd[0], fsr);
      chk(clr, 1'b1);
    end
  endtask

  task t_err;
    begin
      e2 <= 1'b1;
      sup <= 1'b1;
      go(mk(5'h04, `OP3_DOUBLE, 1'b0, 13'h0002), 32'h0000_0600, 32'h0);
      chk(res, `TRAP_ACCESS);
      chk({i_mem_model.nw, i_mem_model.wa[0]}, {32'd2, 32'h0000_0600});
      e2 <= 1'b0;
    end
  endtask

  // ==========================================
  // verdict and hang guard
  task conclude;
    begin
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask

  // whole run is a few hundred cycles
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      num_errors = num_errors + 1;
      conclude;
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    t_word;
    t_small;
    t_pair;
    t_alt;
    t_traps;
    t_float;
    t_err;
    conclude;
  end
endmodule
